// *** design/ahs_pkg.sv ***
// Constants and types shared by the axis homing sequencer.
// Assumes a single system clock domain; switch and index pins arrive asynchronous.
package ahs_pkg;

  // ------------------------------------------------------------
  // Method numbers
  // ------------------------------------------------------------
  localparam int METHOD_W = 4;
  localparam logic [METHOD_W-1:0] METHOD_MIN = 4'h1;
  localparam logic [METHOD_W-1:0] METHOD_MAX = 4'hA;
  localparam logic [METHOD_W-1:0] M_NEG_LIM = 4'h1;
  localparam logic [METHOD_W-1:0] M_POS_LIM = 4'h2;
  localparam logic [METHOD_W-1:0] M_HOME_3 = 4'h3;
  localparam logic [METHOD_W-1:0] M_HOME_4 = 4'h4;
  localparam logic [METHOD_W-1:0] M_HOME_5 = 4'h5;
  localparam logic [METHOD_W-1:0] M_HOME_6 = 4'h6;
  localparam logic [METHOD_W-1:0] M_LIM_7 = 4'h7;
  localparam logic [METHOD_W-1:0] M_LIM_8 = 4'h8;
  localparam logic [METHOD_W-1:0] M_LIM_9 = 4'h9;
  localparam logic [METHOD_W-1:0] M_LIM_10 = 4'hA;

  // ------------------------------------------------------------
  // Widths, directions, synchroniser
  // ------------------------------------------------------------
  localparam int SPEED_W = 16;
  localparam int POS_W = 32;
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;
  localparam int SYNC_STAGES = 2;

  // Bit positions of the synchronised pin vector
  localparam int PIN_NEG = 0;
  localparam int PIN_POS = 1;
  localparam int PIN_HOME = 2;
  localparam int PIN_INDEX = 3;
  localparam int PIN_COUNT = 4;

  // ------------------------------------------------------------
  // Search legs
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LEG_IDLE,
    LEG_A,
    LEG_B,
    LEG_C,
    LEG_D,
    LEG_E,
    LEG_IDX,
    LEG_DONE
  } ahs_leg_type;

endpackage

// *** design/ahs_sync.sv ***
// Multi-bit two-flop synchroniser for asynchronous pin levels.
// Assumes each bit is an independent slow level; no bus coherency is implied.
`timescale 1ns/10ps
module ahs_sync #(
  parameter int WIDTH = 4,
  parameter int STAGES = 2
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  // ------------------------------------------------------------
  // Shift chain; only the last stage is visible
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_q[i] <= '0;
    end
    else
    begin
      stage_q[0] <= async_in;
      for (int i = 1; i < STAGES; i++)
        stage_q[i] <= stage_q[i-1];
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule // ahs_sync

// *** design/ahs_sequencer.sv ***
// Homing sequencer for one motion axis, methods 1 to 10.
// Assumes command and speed inputs are synchronous to sys_clk; switch and
// index pins are asynchronous and pass the synchroniser first.
`timescale 1ns/10ps
module ahs_sequencer
  import ahs_pkg::*;
#(
  parameter int SPD_W = SPEED_W,
  parameter int POSN_W = POS_W
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic homing_command,
  input wire logic homing_abort,
  input wire logic [METHOD_W-1:0] method_sel,
  input wire logic [SPD_W-1:0] fast_speed,
  input wire logic [SPD_W-1:0] slow_speed,
  input wire logic [POSN_W-1:0] axis_position,
  input wire logic [POSN_W-1:0] home_reference,
  input wire logic neg_limit,
  input wire logic pos_limit,
  input wire logic home_switch,
  input wire logic index_pulse,
  output logic move_en,
  output logic move_dir,
  output logic [SPD_W-1:0] move_speed,
  output logic busy,
  output logic home_done,
  output logic method_error,
  output logic limit_fault,
  output logic [POSN_W-1:0] home_latched,
  output logic pos_load,
  output logic [POSN_W-1:0] pos_load_value
);

  // ------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ------------------------------------------------------------
  logic [PIN_COUNT-1:0] pins_raw, pins_s;
  logic neg_s, pos_s, home_s, index_s;
  logic index_prev_q, index_rise, cmd_prev_q, cmd_rise;

  assign pins_raw = {index_pulse, home_switch, pos_limit, neg_limit};
  ahs_sync #(
    .WIDTH(PIN_COUNT),
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );
  assign neg_s = pins_s[PIN_NEG];
  assign pos_s = pins_s[PIN_POS];
  assign home_s = pins_s[PIN_HOME];
  assign index_s = pins_s[PIN_INDEX];
  assign index_rise = index_s & ~index_prev_q;
  assign cmd_rise = homing_command & ~cmd_prev_q;

  // ------------------------------------------------------------
  // Method decode
  // ------------------------------------------------------------
  ahs_leg_type leg_q, leg_d;
  logic [METHOD_W-1:0] method_q;
  logic [SPD_W-1:0] speed_d;
  logic dir_q, dir_d, fast_q, fast_d, step, latch_home;
  logic sel_valid, start_sw, start_a_dir, start_b_dir, m_lim_group;
  logic b_release, b_exit_dir, lim_reversal, idle_like, fault_hit;
  logic stop_now, start_now, run_d;
  // Command accepted only when no search is running
  assign idle_like = (leg_q == LEG_IDLE) || (leg_q == LEG_DONE);
  assign sel_valid = (method_sel >= METHOD_MIN) && (method_sel <= METHOD_MAX);
  // Switch that decides the starting circumstance
  assign start_sw = (method_sel == M_NEG_LIM) ? neg_s :
                    (method_sel == M_POS_LIM) ? pos_s : home_s;
  // Direction of the fast first leg
  assign start_a_dir = ((method_sel == M_NEG_LIM) || (method_sel == M_HOME_5) ||
                        (method_sel == M_HOME_6)) ? DIR_NEG : DIR_POS;
  // Direction of the slow leg when starting on the switch
  assign start_b_dir = ((start_a_dir == DIR_NEG) || (method_sel == M_LIM_9) ||
                        (method_sel == M_LIM_10)) ? DIR_POS : DIR_NEG;
  assign m_lim_group = (method_q >= M_LIM_7) && (method_q <= M_LIM_10);
  // Slow leg ends when its switch releases
  assign b_release = (method_q == M_NEG_LIM) ? ~neg_s :
                     (method_q == M_POS_LIM) ? ~pos_s : ~home_s;
  // Methods 4 and 8 reverse to positive, 6 and 9 to negative, others keep going
  assign b_exit_dir = ((method_q == M_HOME_4) || (method_q == M_LIM_8)) ? DIR_POS :
                      ((method_q == M_HOME_6) || (method_q == M_LIM_9)) ? DIR_NEG :
                      dir_q;
  // Positive limit reached during the fast positive search, home not seen
  assign lim_reversal = m_lim_group && pos_s && ~home_s;
  // Travel into an active limit that the method does not use
  assign fault_hit = ~step && ~idle_like &&
                     (((dir_q == DIR_NEG) && neg_s && (method_q != M_NEG_LIM)) ||
                      ((dir_q == DIR_POS) && pos_s && (method_q != M_POS_LIM) &&
                       !(m_lim_group && (leg_q == LEG_A))));

  // ------------------------------------------------------------
  // Leg sequencing
  // ------------------------------------------------------------
  always_comb
  begin
    leg_d = leg_q;
    dir_d = dir_q;
    fast_d = fast_q;
    step = 1'b0;
    latch_home = 1'b0;
    unique case (leg_q)
      LEG_IDLE, LEG_DONE:
      begin
        if (cmd_rise && sel_valid)
        begin
          step = 1'b1;
          if (start_sw)
          begin
            leg_d = LEG_B;
            dir_d = start_b_dir;
            fast_d = 1'b0;
          end
          else
          begin
            leg_d = LEG_A;
            dir_d = start_a_dir;
            fast_d = 1'b1;
          end
        end
      end
      LEG_A:
      begin
        unique case (method_q)
          M_NEG_LIM:
          begin
            step = neg_s;
            leg_d = LEG_B;
            dir_d = DIR_POS;
          end
          M_POS_LIM:
          begin
            step = pos_s;
            leg_d = LEG_B;
            dir_d = DIR_NEG;
          end
          M_HOME_3, M_LIM_7:
          begin
            step = home_s;
            leg_d = LEG_B;
            dir_d = DIR_NEG;
          end
          M_HOME_4, M_LIM_8:
          begin
            step = home_s;
            leg_d = LEG_IDX;
            dir_d = DIR_POS;
          end
          M_HOME_6:
          begin
            step = home_s;
            leg_d = LEG_IDX;
            dir_d = DIR_NEG;
          end
          default:
          begin
            step = home_s;
            leg_d = LEG_B;
            dir_d = DIR_POS;
          end
        endcase
        fast_d = 1'b0;
        if (!step && lim_reversal)
        begin
          step = 1'b1;
          leg_d = LEG_C;
          dir_d = DIR_NEG;
          fast_d = 1'b1;
        end
      end
      LEG_B:
      begin
        step = b_release;
        leg_d = LEG_IDX;
        dir_d = b_exit_dir;
        fast_d = 1'b0;
      end
      LEG_C:
      begin
        step = home_s;
        fast_d = 1'b0;
        unique case (method_q)
          M_LIM_7:
          begin
            leg_d = LEG_B;
            dir_d = DIR_NEG;
          end
          M_LIM_8:
          begin
            leg_d = LEG_D;
            dir_d = DIR_NEG;
            fast_d = 1'b1;
          end
          M_LIM_9:
          begin
            leg_d = LEG_IDX;
            dir_d = DIR_NEG;
          end
          default:
          begin
            leg_d = LEG_B;
            dir_d = DIR_POS;
          end
        endcase
      end
      LEG_D:
      begin
        step = ~home_s;
        leg_d = LEG_E;
        dir_d = DIR_POS;
        fast_d = 1'b1;
      end
      LEG_E:
      begin
        step = home_s;
        leg_d = LEG_IDX;
        dir_d = DIR_POS;
        fast_d = 1'b0;
      end
      LEG_IDX:
      begin
        step = index_rise;
        latch_home = index_rise;
        leg_d = LEG_DONE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  assign start_now = idle_like && cmd_rise && sel_valid;
  assign stop_now = ~idle_like && (homing_abort || fault_hit);
  assign speed_d = fast_d ? fast_speed : slow_speed;
  assign run_d = ~stop_now && (step ? (leg_d != LEG_DONE) && (leg_d != LEG_IDLE) : ~idle_like);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      leg_q <= LEG_IDLE;
      method_q <= METHOD_MIN;
      dir_q <= DIR_POS;
      fast_q <= 1'b0;
      cmd_prev_q <= 1'b0;
      index_prev_q <= 1'b0;
    end
    else
    begin
      cmd_prev_q <= homing_command;
      index_prev_q <= index_s;
      if (start_now)
        method_q <= method_sel;
      if (stop_now)
        leg_q <= LEG_IDLE;
      else if (step)
      begin
        leg_q <= leg_d;
        dir_q <= dir_d;
        fast_q <= fast_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      move_en <= 1'b0;
      move_dir <= DIR_POS;
      move_speed <= '0;
      busy <= 1'b0;
      home_done <= 1'b0;
      method_error <= 1'b0;
      limit_fault <= 1'b0;
      home_latched <= '0;
      pos_load <= 1'b0;
      pos_load_value <= '0;
    end
    else
    begin
      move_en <= run_d;
      busy <= run_d;
      move_dir <= step ? dir_d : dir_q;
      move_speed <= run_d ? (step ? speed_d : (fast_q ? fast_speed : slow_speed)) : '0;
      pos_load <= latch_home;
      if (latch_home)
      begin
        home_latched <= axis_position;
        pos_load_value <= home_reference;
        home_done <= 1'b1;
      end
      else if (cmd_rise && idle_like)
        home_done <= 1'b0;
      if (cmd_rise && idle_like)
        method_error <= ~sel_valid;
      if (fault_hit && !homing_abort)
        limit_fault <= 1'b1;
      else if (start_now)
        limit_fault <= 1'b0;
    end
  end

endmodule // ahs_sequencer

// *** test/ahs_checker.sv ***
// Concurrent checks on the homing sequencer ports.
// Assumes speeds are held constant while a search runs.
`timescale 1ns/10ps
module ahs_checker
  import ahs_pkg::*;
#(
  parameter int SPD_W = SPEED_W,
  parameter int POSN_W = POS_W
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic homing_command,
  input wire logic [METHOD_W-1:0] method_sel,
  input wire logic [SPD_W-1:0] fast_speed,
  input wire logic [SPD_W-1:0] slow_speed,
  input wire logic [POSN_W-1:0] axis_position,
  input wire logic [POSN_W-1:0] home_reference,
  input wire logic move_en,
  input wire logic [SPD_W-1:0] move_speed,
  input wire logic busy,
  input wire logic home_done,
  input wire logic method_error,
  input wire logic [POSN_W-1:0] home_latched,
  input wire logic pos_load,
  input wire logic [POSN_W-1:0] pos_load_value
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_BUSY_MOVE: assert property (busy == move_en)
    else $error("busy differs from move_en");
  AST_START: assert property ($rose(homing_command) && !busy && method_sel >= METHOD_MIN &&
    method_sel <= METHOD_MAX |-> ##[1:2] move_en)
    else $error("valid command did not start motion");
  AST_BAD_METHOD: assert property ($rose(homing_command) && !busy &&
    (method_sel < METHOD_MIN || method_sel > METHOD_MAX) |-> ##[1:2] (method_error && !move_en))
    else $error("invalid method not refused");
  AST_SPEED_SRC: assert property (move_en |->
    (move_speed == $past(fast_speed) || move_speed == $past(slow_speed)))
    else $error("move speed is neither phase speed");
  AST_STOP_ZERO: assert property (!move_en |-> move_speed == '0)
    else $error("speed not zero while stopped");
  AST_LOAD_PULSE: assert property (pos_load |=> !pos_load)
    else $error("position load longer than one cycle");
  AST_LOAD_STATE: assert property (pos_load |->
    home_done && !busy && pos_load_value == $past(home_reference))
    else $error("home load without stop or reference");
  AST_LATCH_POS: assert property (pos_load |-> home_latched == $past(axis_position))
    else $error("latched home differs from axis position");
  AST_DONE_HOLD: assert property (home_done && !homing_command |=> home_done)
    else $error("done dropped without a command");
  AST_DONE_STILL: assert property (home_done |-> !move_en)
    else $error("axis moving while done");
endmodule // ahs_checker

bind ahs_sequencer ahs_checker #(.SPD_W(SPD_W), .POSN_W(POSN_W)) chk_u (.sys_clk, .rstn,
  .homing_command, .method_sel, .fast_speed, .slow_speed, .axis_position, .home_reference,
  .move_en, .move_speed, .busy, .home_done, .method_error, .home_latched, .pos_load,
  .pos_load_value);

// *** test/ahs_axis_model.sv ***
// Behavioural servo axis: position, limit and home zones, encoder index.
// Assumes one count of travel per unit of move_speed per cycle.
`timescale 1ns/10ps
module ahs_axis_model
  import ahs_pkg::*;
#(
  parameter logic [POS_W-1:0] NEG_EDGE = 32'h64,
  parameter logic [POS_W-1:0] POS_EDGE = 32'hFA0,
  parameter logic [POS_W-1:0] HOME_LO = 32'h5DC,
  parameter logic [POS_W-1:0] HOME_HI = 32'h6A4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic move_en,
  input wire logic move_dir,
  input wire logic [SPEED_W-1:0] move_speed,
  input wire logic pos_load,
  input wire logic [POS_W-1:0] pos_load_value,
  input wire logic set_en,
  input wire logic [POS_W-1:0] set_val,
  output logic [POS_W-1:0] axis_position,
  output logic neg_limit,
  output logic pos_limit,
  output logic home_switch,
  output logic index_pulse
);
  // ------------------------------------------------------------
  // Travel and switch zones
  // ------------------------------------------------------------
  wire logic [POS_W-1:0] step = {16'h0, move_speed};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      axis_position <= 32'h800;
    else if (set_en)
      axis_position <= set_val;
    else if (pos_load)
      axis_position <= pos_load_value;
    else if (move_en)
      axis_position <= (move_dir == DIR_POS) ? axis_position + step : axis_position - step;
  end

  assign neg_limit = axis_position < NEG_EDGE;
  assign pos_limit = axis_position > POS_EDGE;
  assign home_switch = axis_position >= HOME_LO && axis_position < HOME_HI;
  // Index mark every 64 counts, two counts wide
  assign index_pulse = axis_position[5:0] < 6'h2;
endmodule // ahs_axis_model

// *** test/ahs_sequencer_test.sv ***
// Self-checking bench for the homing sequencer against a behavioural axis.
// Assumes phase speeds of 4 and 1 counts per cycle.
`timescale 1ns/10ps
module ahs_sequencer_test
  import ahs_pkg::*;
;
  typedef struct packed {
    logic [3:0] m;
    logic [15:0] at;
    logic [1:0] mv;
    logic [15:0] mark;
  } ahs_row_type;
  // Start position, first {dir, fast}, expected index mark
  ahs_row_type rows [23] = '{
    '{4'h1, 16'h320, 2'h1, 16'h80},
    '{4'h1, 16'h32, 2'h2, 16'h80},
    '{4'h2, 16'hBB8, 2'h3, 16'hF80},
    '{4'h2, 16'hFD2, 2'h0, 16'hF80},
    '{4'h3, 16'h3E8, 2'h3, 16'h5C0},
    '{4'h3, 16'h640, 2'h0, 16'h5C0},
    '{4'h4, 16'h3E8, 2'h3, 16'h600},
    '{4'h4, 16'h640, 2'h0, 16'h600},
    '{4'h5, 16'h640, 2'h2, 16'h6C0},
    '{4'h5, 16'h9C4, 2'h1, 16'h6C0},
    '{4'h6, 16'h640, 2'h2, 16'h680},
    '{4'h6, 16'h9C4, 2'h1, 16'h680},
    '{4'h7, 16'h3E8, 2'h3, 16'h5C0},
    '{4'h7, 16'h708, 2'h3, 16'h5C0},
    '{4'h8, 16'h3E8, 2'h3, 16'h600},
    '{4'h8, 16'h640, 2'h0, 16'h600},
    '{4'h8, 16'h708, 2'h3, 16'h600},
    '{4'h9, 16'h3E8, 2'h3, 16'h680},
    '{4'h9, 16'h640, 2'h2, 16'h680},
    '{4'h9, 16'h708, 2'h3, 16'h680},
    '{4'hA, 16'h3E8, 2'h3, 16'h6C0},
    '{4'hA, 16'h640, 2'h2, 16'h6C0},
    '{4'hA, 16'h708, 2'h3, 16'h6C0}
  };
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic homing_command = 1'b0;
  logic homing_abort = 1'b0;
  logic set_en = 1'b0;
  logic [METHOD_W-1:0] method_sel = 4'h0;
  logic [SPEED_W-1:0] fast_speed = 16'h4;
  logic [SPEED_W-1:0] slow_speed = 16'h1;
  logic [POS_W-1:0] set_val = 32'h0;
  logic [POS_W-1:0] home_reference = 32'h800;
  wire logic move_en, move_dir, busy, home_done, method_error, limit_fault, pos_load;
  wire logic neg_limit, pos_limit, home_switch, index_pulse;
  wire logic [SPEED_W-1:0] move_speed;
  wire logic [POS_W-1:0] home_latched, pos_load_value, axis_position;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  ahs_sequencer dut_u (.sys_clk, .rstn, .homing_command, .homing_abort, .method_sel,
    .fast_speed, .slow_speed, .axis_position, .home_reference, .neg_limit, .pos_limit,
    .home_switch, .index_pulse, .move_en, .move_dir, .move_speed, .busy, .home_done,
    .method_error, .limit_fault, .home_latched, .pos_load, .pos_load_value);
  ahs_axis_model axis_u (.sys_clk, .rstn, .move_en, .move_dir, .move_speed, .pos_load,
    .pos_load_value, .set_en, .set_val, .axis_position, .neg_limit, .pos_limit, .home_switch,
    .index_pulse);

  always #12.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 32'h15F90)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Place the axis, let switches settle, then issue one command edge
  task automatic start(input logic [3:0] m, input logic [15:0] at);
    @(posedge sys_clk);
    set_en <= 1'b1;
    set_val <= {16'h0, at};
    @(posedge sys_clk);
    set_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    method_sel <= m;
    homing_command <= 1'b1;
    @(posedge sys_clk);
    homing_command <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (home_done !== 1'b1 && n < 4000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("home_done", 1'b1, home_done);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1;
    chk("reset move_en", 1'b0, move_en);
    chk("reset move_dir", 1'b1, move_dir);
    @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      start(rows[i].m, rows[i].at);
      chk("home_done", 1'b0, home_done);
      chk("move_dir", rows[i].mv[1], move_dir);
      chk("move_speed", rows[i].mv[0] ? fast_speed : slow_speed, move_speed);
      wait_done();
      chk("home_latched", 1'b1, (home_latched - rows[i].mark + 32'h7) < 32'hE);
      chk("pos_load_value", home_reference, pos_load_value);
      chk("limit_fault", 1'b0, limit_fault);
      @(posedge sys_clk);
      #1;
      chk("axis_position", home_reference, axis_position);
      chk("move_en", 1'b0, move_en);
    end
    // Fast negative search into an unused limit stops with a fault
    start(4'h6, 16'h3E8);
    repeat (300) @(posedge sys_clk);
    #1;
    chk("fault limit_fault", 1'b1, limit_fault);
    chk("fault busy", 1'b0, busy);
    chk("fault home_done", 1'b0, home_done);
    foreach (rows[i])
    begin
      if (i < 3)
      begin
        start(i == 0 ? 4'h0 : (i == 1 ? 4'hB : 4'hF), 16'h3E8);
        chk("method_error", 1'b1, method_error);
        chk("move_en", 1'b0, move_en);
      end
    end
    // Command while busy is ignored, abort stops the search
    start(4'h3, 16'h3E8);
    repeat (10) @(posedge sys_clk);
    method_sel <= 4'h1;
    homing_command <= 1'b1;
    @(posedge sys_clk);
    homing_command <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("busy", 1'b1, busy);
    chk("move_dir", DIR_POS, move_dir);
    @(posedge sys_clk);
    homing_abort <= 1'b1;
    @(posedge sys_clk);
    homing_abort <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("abort busy", 1'b0, busy);
    chk("abort home_done", 1'b0, home_done);
    // Reset in mid search, then a full run again
    start(4'h8, 16'h708);
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("reset move_en", 1'b0, move_en);
    chk("reset move_speed", 16'h0, move_speed);
    chk("reset move_dir", 1'b1, move_dir);
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    start(4'h3, 16'h640);
    wait_done();
    end_sim();
  end
endmodule // ahs_sequencer_test
